// file: rbc_pkg.sv
package rbc_pkg;

  // ****************************************
  // register indexes (byte address = 4 * index)
  // ****************************************
  localparam logic [7:0] IDX_CHIP_CTRL = 8'h9F;
  localparam logic [7:0] IDX_UNLOCK    = 8'hC7;
  localparam logic [7:0] IDX_CFG_BOD   = 8'hE2;
  localparam logic [7:0] IDX_CFG_WDT   = 8'hE3;
  localparam logic [7:0] IDX_STATUS    = 8'hE4;

  // ****************************************
  // unlock keys and reset values
  // ****************************************
  localparam logic [7:0] KEY_FIRST     = 8'hAA;
  localparam logic [7:0] KEY_SECOND    = 8'h55;
  localparam logic [7:0] CFG_RESET     = 8'hFF;
  localparam logic [7:0] CC_RESET      = 8'h00;
  localparam logic [7:0] CC_RW_MASK    = 8'h73;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CC_SOFT_RESET   = 7;
  localparam int CC_BOOT_SELECT  = 1;
  localparam int CFG_BOD_DETECT  = 7;
  localparam int CFG_BOD_LVL_HI  = 6;
  localparam int CFG_BOD_LVL_LO  = 5;
  localparam int CFG_BOD_RESET   = 4;
  localparam int CFG_WDT_DEFAULT = 7;
  localparam int ST_BOR_FLAG     = 2;
  localparam int ST_CPU_RESET    = 0;

  // ****************************************
  // timing, in machine cycles and clocks
  // ****************************************
  localparam int MC_CLKS  = 12;
  localparam int PIN_MC   = 2;
  localparam int PIN_CYC  = PIN_MC * MC_CLKS;
  localparam int HOLD_MC  = 2;
  localparam int HOLD_CYC = HOLD_MC * MC_CLKS;

  typedef enum logic [1:0] {
    RBC_KEY_IDLE,
    RBC_KEY_HALF,
    RBC_KEY_OPEN
  } rbc_key_state_t;

endpackage

// file: rbc_pin_qual.sv
`timescale 1ns/10ps
module rbc_pin_qual #(
  parameter int CYC = rbc_pkg::PIN_CYC
) (
  input  wire logic clk_i,   // system clock
  input  wire logic srst_i,  // sync reset
  input  wire logic pin_i,   // reset pin level
  output logic      valid_o  // pin held long enough
);

  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;

  // count clocks of pin high, saturating one short of the window
  assign nxt_cnt = !pin_i ? 8'h00 :
                   (cnt_ff == 8'(CYC - 1)) ? cnt_ff : cnt_ff + 8'h01;
  // a glitch shorter than the window never reaches the sequencer
  assign valid_o = pin_i & (cnt_ff == 8'(CYC - 1));

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_ff <= 8'h00;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  pin_window_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    valid_o |-> pin_i && $past(pin_i) && $past(pin_i, 2) && cnt_ff != 8'h00)
    else $error("reset pin qualified too early");

endmodule // rbc_pin_qual

// file: rbc_reset_stretch.sv
`timescale 1ns/10ps
module rbc_reset_stretch #(
  parameter int CYC = rbc_pkg::HOLD_CYC
) (
  input  wire logic clk_i,    // system clock
  input  wire logic srst_i,   // sync reset
  input  wire logic trig_i,   // any reset source
  output logic      active_o, // cpu held in reset
  output logic      done_o    // one-cycle end of sequence
);

  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;

  // retrigger restarts the window, so a held pin keeps the cpu down
  assign nxt_cnt  = trig_i ? 8'(CYC) : (cnt_ff != 8'h00) ? cnt_ff - 8'h01 : 8'h00;
  assign active_o = (cnt_ff != 8'h00);
  assign done_o   = (cnt_ff == 8'h01) & ~trig_i;

  // power-up also runs a full window so config is loaded before fetch
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_ff <= 8'(CYC);
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  hold_length_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    trig_i |=> active_o [*8])
    else $error("reset window shorter than expected");

endmodule // rbc_reset_stretch

// file: rbc_reset_ctrl.sv
// Our own choice: the Wishbone register port.
`timescale 1ns/10ps
// Functional notes
// - reset pin valid after two machine cycles high
// - writing soft reset bit starts full reset
// - hardware clears soft reset bit when done
// - boot select zero boots application memory
// - boot choice applies after every reset source
// - config bit 7 enables brown-out detection
// - config bits 6:5 pick brown-out level
// - config bit 4 lets brown-out reset device
// - config bit 7 zero enables watchdog
// - unprogrammed config bytes read all ones
// - brown-out reset sets flag, software clears
module rbc_reset_ctrl (
  input  wire logic        clk_i,          // system clock, 100 MHz
  input  wire logic        srst_i,         // sync reset, power-on
  input  wire logic        wb_cyc_i,       // wishbone cycle
  input  wire logic        wb_stb_i,       // wishbone strobe
  input  wire logic        wb_we_i,        // wishbone write
  input  wire logic [9:0]  wb_adr_i,       // wishbone byte address
  input  wire logic [3:0]  wb_sel_i,       // wishbone byte lanes
  input  wire logic [31:0] wb_dat_i,       // wishbone write data
  output logic      [31:0] wb_dat_o,       // wishbone read data
  output logic             wb_ack_o,       // wishbone acknowledge
  input  wire logic        rst_pin_i,      // external reset pin
  input  wire logic        bod_cmp_i,      // brown-out comparator
  output logic             cpu_reset_o,    // cpu held in reset
  output logic             boot_loader_o,  // 1 loader, 0 application
  output logic             bod_enable_o,   // brown-out detector on
  output logic      [1:0]  bod_level_o,    // threshold code
  output logic             bod_reset_en_o, // brown-out may reset
  output logic             wdt_enable_o    // watchdog on after reset
);

  // ****************************************
  // state
  // ****************************************
  logic                  ack_ff;
  logic [31:0]           dat_ff;
  rbc_pkg::rbc_key_state_t key_ff;
  rbc_pkg::rbc_key_state_t nxt_key;
  logic [7:0]            cc_ff;
  logic                  soft_trig_ff;
  logic [7:0]            cfg_bod_ff;
  logic [7:0]            cfg_wdt_ff;
  logic                  bor_flag_ff;
  logic                  boot_ff;
  logic                  bod_en_ff;
  logic [1:0]            bod_lvl_ff;
  logic                  bod_rst_ff;
  logic                  wdt_en_ff;
  logic [7:0]            rd_byte;

  // ****************************************
  // bus decode
  // ****************************************
  wire [7:0] idx     = wb_adr_i[9:2];
  wire       bus_req = wb_cyc_i & wb_stb_i;
  // writes land on the ack edge, the only edge the master honours
  wire       wr_en   = bus_req & wb_we_i & ack_ff & wb_sel_i[0];
  wire [7:0] wr_byte = wb_dat_i[7:0];
  wire       hit_cc  = (idx == rbc_pkg::IDX_CHIP_CTRL);
  wire       hit_key = (idx == rbc_pkg::IDX_UNLOCK);
  wire       hit_cb  = (idx == rbc_pkg::IDX_CFG_BOD);
  wire       hit_cw  = (idx == rbc_pkg::IDX_CFG_WDT);
  wire       hit_st  = (idx == rbc_pkg::IDX_STATUS);

  // ****************************************
  // reset sources
  // ****************************************
  wire pin_valid;
  wire seq_done;
  // protected write only when the unlock pair came just before
  wire cc_wr    = wr_en & hit_cc & (key_ff == rbc_pkg::RBC_KEY_OPEN);
  wire sw_start = cc_wr & wr_byte[rbc_pkg::CC_SOFT_RESET];
  wire bor_evt  = bod_cmp_i & bod_en_ff & bod_rst_ff;
  wire seq_trig = pin_valid | sw_start | bor_evt;
  wire flag_clr = wr_en & hit_st & ~wr_byte[rbc_pkg::ST_BOR_FLAG];

  rbc_pin_qual #(
    .CYC (rbc_pkg::PIN_CYC)
  ) u_pin (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .pin_i   (rst_pin_i),
    .valid_o (pin_valid)
  );

  rbc_reset_stretch #(
    .CYC (rbc_pkg::HOLD_CYC)
  ) u_seq (
    .clk_i    (clk_i),
    .srst_i   (srst_i),
    .trig_i   (seq_trig),
    .active_o (cpu_reset_o),
    .done_o   (seq_done)
  );

  // ****************************************
  // unlock sequence
  // ****************************************
  // any other write between keys drops back, reads do not disturb it
  always_comb begin
    nxt_key = key_ff;
    if (wr_en) begin
      case (key_ff)
        rbc_pkg::RBC_KEY_IDLE: begin
          if (hit_key && wr_byte == rbc_pkg::KEY_FIRST) begin
            nxt_key = rbc_pkg::RBC_KEY_HALF;
          end
        end
        rbc_pkg::RBC_KEY_HALF: begin
          if (hit_key && wr_byte == rbc_pkg::KEY_SECOND) begin
            nxt_key = rbc_pkg::RBC_KEY_OPEN;
          end else begin
            nxt_key = rbc_pkg::RBC_KEY_IDLE;
          end
        end
        default: begin
          nxt_key = rbc_pkg::RBC_KEY_IDLE; // one write per unlock
        end
      endcase
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  always_comb begin
    if (hit_cc) begin
      rd_byte = {soft_trig_ff, cc_ff[6:0]};
    end else if (hit_cb) begin
      rd_byte = cfg_bod_ff;
    end else if (hit_cw) begin
      rd_byte = cfg_wdt_ff;
    end else if (hit_st) begin
      rd_byte = {5'h00, bor_flag_ff, 1'b0, cpu_reset_o};
    end else begin
      rd_byte = 8'h00; // unlock port and unmapped read zero
    end
  end

  // wishbone slave: one wait state, ack drops the cycle after it rises
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= bus_req & ~ack_ff;
      dat_ff <= {24'h00_0000, rd_byte};
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

  // ****************************************
  // software registers
  // ****************************************
  // soft reset bit: set wins over the hardware clear
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      key_ff       <= rbc_pkg::RBC_KEY_IDLE;
      cc_ff        <= rbc_pkg::CC_RESET;
      soft_trig_ff <= 1'b0;
    end else begin
      key_ff       <= nxt_key;
      cc_ff        <= cc_wr ? (wr_byte & rbc_pkg::CC_RW_MASK) : cc_ff;
      soft_trig_ff <= sw_start | (soft_trig_ff & ~seq_done);
    end
  end

  // config bytes keep their value across soft resets
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cfg_bod_ff <= rbc_pkg::CFG_RESET;
      cfg_wdt_ff <= rbc_pkg::CFG_RESET;
    end else begin
      cfg_bod_ff <= (wr_en & hit_cb) ? wr_byte : cfg_bod_ff;
      cfg_wdt_ff <= (wr_en & hit_cw) ? wr_byte : cfg_wdt_ff;
    end
  end

  // only power-on resets the flag; a new event beats a software clear
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      bor_flag_ff <= 1'b0;
    end else begin
      bor_flag_ff <= bor_evt | (bor_flag_ff & ~flag_clr);
    end
  end

  // ****************************************
  // live controls
  // ****************************************
  // reloaded on every reset cycle, frozen while the cpu runs
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      boot_ff    <= rbc_pkg::CC_RESET[rbc_pkg::CC_BOOT_SELECT];
      bod_en_ff  <= rbc_pkg::CFG_RESET[rbc_pkg::CFG_BOD_DETECT];
      bod_lvl_ff <= rbc_pkg::CFG_RESET[rbc_pkg::CFG_BOD_LVL_HI:rbc_pkg::CFG_BOD_LVL_LO];
      bod_rst_ff <= rbc_pkg::CFG_RESET[rbc_pkg::CFG_BOD_RESET];
      wdt_en_ff  <= ~rbc_pkg::CFG_RESET[rbc_pkg::CFG_WDT_DEFAULT];
    end else if (cpu_reset_o) begin
      boot_ff    <= cc_ff[rbc_pkg::CC_BOOT_SELECT];
      bod_en_ff  <= cfg_bod_ff[rbc_pkg::CFG_BOD_DETECT];
      bod_lvl_ff <= cfg_bod_ff[rbc_pkg::CFG_BOD_LVL_HI:rbc_pkg::CFG_BOD_LVL_LO];
      bod_rst_ff <= cfg_bod_ff[rbc_pkg::CFG_BOD_RESET];
      wdt_en_ff  <= ~cfg_wdt_ff[rbc_pkg::CFG_WDT_DEFAULT];
    end
  end

  assign boot_loader_o  = boot_ff;
  assign bod_enable_o   = bod_en_ff;
  assign bod_level_o    = bod_lvl_ff;
  assign bod_reset_en_o = bod_rst_ff;
  assign wdt_enable_o   = wdt_en_ff;

  // ****************************************
  // checks
  // ****************************************
  ack_pulse_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  sw_start_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    sw_start |=> cpu_reset_o && soft_trig_ff)
    else $error("soft reset write did not reset the cpu");

  sw_clear_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    $fell(cpu_reset_o) |-> !soft_trig_ff)
    else $error("soft reset bit still set after sequence");

  boot_pick_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    $fell(cpu_reset_o) |-> boot_loader_o == $past(cc_ff[rbc_pkg::CC_BOOT_SELECT]))
    else $error("boot memory does not follow boot select");

  bod_live_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    $fell(cpu_reset_o) |-> bod_enable_o == $past(cfg_bod_ff[rbc_pkg::CFG_BOD_DETECT])
      && bod_level_o == $past(cfg_bod_ff[6:5]))
    else $error("brown-out controls not reloaded");

  bor_reset_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (bod_cmp_i && bod_en_ff && bod_rst_ff) |=> cpu_reset_o && bor_flag_ff)
    else $error("brown-out event did not reset and flag");

  bor_quiet_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (!cpu_reset_o && !bod_rst_ff && !pin_valid && !sw_start) |=> !cpu_reset_o)
    else $error("reset with brown-out reset disabled");

  wdt_default_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    $fell(cpu_reset_o) |-> wdt_enable_o != $past(cfg_wdt_ff[rbc_pkg::CFG_WDT_DEFAULT]))
    else $error("watchdog default wrong after reset");

  cfg_blank_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    $fell(srst_i) |-> cfg_bod_ff == 8'hFF && cfg_wdt_ff == 8'hFF && bod_enable_o)
    else $error("config bytes not all ones after power-on");

  bor_flag_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (bor_flag_ff && !flag_clr) |=> bor_flag_ff)
    else $error("brown-out flag lost without a clear");

  locked_write_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (wr_en && hit_cc && key_ff != rbc_pkg::RBC_KEY_OPEN) |=> $stable(cc_ff) && !sw_start)
    else $error("chip control changed without unlock");

  pin_reset_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    pin_valid |=> cpu_reset_o [*3])
    else $error("qualified pin did not hold the cpu");

  // reload checks look one edge after the reset cycle that loaded them
  boot_every_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    cpu_reset_o |=> boot_loader_o == $past(cc_ff[rbc_pkg::CC_BOOT_SELECT]))
    else $error("boot select not reloaded during reset");

  level_reload_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    cpu_reset_o |=> bod_level_o ==
      $past(cfg_bod_ff[rbc_pkg::CFG_BOD_LVL_HI:rbc_pkg::CFG_BOD_LVL_LO]))
    else $error("brown-out level not reloaded during reset");

  soft_bit_run_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    soft_trig_ff |-> cpu_reset_o)
    else $error("soft reset bit set while cpu runs");

  unlock_once_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (wr_en && key_ff == rbc_pkg::RBC_KEY_OPEN) |=> key_ff == rbc_pkg::RBC_KEY_IDLE)
    else $error("unlock not consumed by the next write");

endmodule // rbc_reset_ctrl

// file: tb.sv
`timescale 1ns/10ps
module tb;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic        clk_i;
  logic        srst_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [9:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        rst_pin_i;
  logic        bod_cmp_i;
  logic        cpu_reset_o;
  logic        boot_loader_o;
  logic        bod_enable_o;
  logic [1:0]  bod_level_o;
  logic        bod_reset_en_o;
  logic        wdt_enable_o;
  int          errors;
  int          n_compared;
  logic [31:0] rd;

  rbc_reset_ctrl i_dut (.clk_i(clk_i), .srst_i(srst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rst_pin_i(rst_pin_i),
    .bod_cmp_i(bod_cmp_i), .cpu_reset_o(cpu_reset_o), .boot_loader_o(boot_loader_o),
    .bod_enable_o(bod_enable_o), .bod_level_o(bod_level_o),
    .bod_reset_en_o(bod_reset_en_o), .wdt_enable_o(wdt_enable_o));

  // ****************************************
  // clock and hang guard
  // ****************************************
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    repeat (50000) @(posedge clk_i);
    errors++;
    conclude();
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // classic single cycle; no fixed latency assumed, only a bounded wait
  task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] d,
                    output logic [31:0] q);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      conclude();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, idx, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp, input string what);
    wb(1'b0, idx, 8'h00, rd);
    chk(rd, exp, what);
  endtask

  task automatic unlock();
    wr(rbc_pkg::IDX_UNLOCK, rbc_pkg::KEY_FIRST);
    wr(rbc_pkg::IDX_UNLOCK, rbc_pkg::KEY_SECOND);
  endtask

  task automatic wait_run();
    int n;
    n = 0;
    while (cpu_reset_o !== 1'b0 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 200) begin
      errors++;
      conclude();
    end
  endtask

  // holds the pin for a number of sampled edges, then counts reset cycles seen
  task automatic pin(input int len, output int seen);
    @(posedge clk_i);
    rst_pin_i <= 1'b1;
    repeat (len) @(posedge clk_i);
    rst_pin_i <= 1'b0;
    seen = 0;
    repeat (4) begin
      @(posedge clk_i);
      if (cpu_reset_o === 1'b1) seen++;
    end
    wait_run();
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset_values();
    chk({31'h0, cpu_reset_o}, 32'h1, "cpu reset at start");
    rd_chk(rbc_pkg::IDX_CFG_BOD, 32'h000000FF, "bod cfg reset");
    rd_chk(rbc_pkg::IDX_CFG_WDT, 32'h000000FF, "wdt cfg reset");
    rd_chk(rbc_pkg::IDX_CHIP_CTRL, 32'h00000000, "chip ctrl reset");
    wait_run();
    chk({26'h0, bod_enable_o, bod_level_o, bod_reset_en_o, wdt_enable_o, boot_loader_o},
        32'h0000003C, "live controls default");
    rd_chk(8'h10, 32'h00000000, "unmapped read");
    $display("test reset values done");
  endtask

  task automatic t_pin();
    int s;
    pin(rbc_pkg::PIN_CYC - 1, s);
    chk(s, 0, "short pin pulse");
    pin(rbc_pkg::PIN_CYC, s);
    chk({31'h0, s > 0}, 32'h1, "qualified pin pulse");
    $display("test pin qualify done");
  endtask

  task automatic t_config();
    int s;
    for (int lv = 0; lv < 4; lv++) begin
      wr(rbc_pkg::IDX_CFG_BOD, {1'b1, lv[1:0], 1'b1, 4'hF});
      pin(rbc_pkg::PIN_CYC + 2, s);
      chk({30'h0, bod_level_o}, lv, "bod level");
    end
    wr(rbc_pkg::IDX_CFG_BOD, 8'h0F);
    wr(rbc_pkg::IDX_CFG_WDT, 8'h7F);
    chk({30'h0, bod_enable_o, wdt_enable_o}, 32'h2, "no reload before reset");
    pin(rbc_pkg::PIN_CYC + 2, s);
    chk({29'h0, bod_enable_o, bod_reset_en_o, wdt_enable_o}, 32'h1, "cfg cleared");
    wr(rbc_pkg::IDX_CFG_WDT, 8'hFF);
    pin(rbc_pkg::PIN_CYC + 2, s);
    chk({31'h0, wdt_enable_o}, 32'h0, "watchdog off");
    $display("test config reload done");
  endtask

  task automatic t_soft_reset();
    wr(rbc_pkg::IDX_CHIP_CTRL, 8'h02);
    rd_chk(rbc_pkg::IDX_CHIP_CTRL, 32'h00000000, "locked write ignored");
    unlock();
    wr(rbc_pkg::IDX_UNLOCK, 8'h00);
    wr(rbc_pkg::IDX_CHIP_CTRL, 8'h02);
    rd_chk(rbc_pkg::IDX_CHIP_CTRL, 32'h00000000, "stale unlock ignored");
    unlock();
    wr(rbc_pkg::IDX_CHIP_CTRL, 8'h82);
    @(posedge clk_i); // the reset launches on the ack edge, so look one edge later
    chk({31'h0, cpu_reset_o}, 32'h1, "soft reset starts");
    rd_chk(rbc_pkg::IDX_CHIP_CTRL, 32'h00000082, "soft bit while running");
    rd_chk(rbc_pkg::IDX_STATUS, 32'h00000001, "status shows reset");
    wait_run();
    @(posedge clk_i);
    chk({31'h0, boot_loader_o}, 32'h1, "boot loader after soft");
    rd_chk(rbc_pkg::IDX_CHIP_CTRL, 32'h00000002, "soft bit cleared");
    unlock();
    wr(rbc_pkg::IDX_CHIP_CTRL, 8'h80);
    @(posedge clk_i);
    chk({31'h0, cpu_reset_o}, 32'h1, "second soft reset starts");
    wait_run();
    @(posedge clk_i);
    chk({31'h0, boot_loader_o}, 32'h0, "boot application");
    $display("test soft reset done");
  endtask

  task automatic t_brownout();
    int s;
    wr(rbc_pkg::IDX_CFG_BOD, 8'hEF);
    pin(rbc_pkg::PIN_CYC + 2, s);
    @(posedge clk_i);
    bod_cmp_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk({31'h0, cpu_reset_o}, 32'h0, "brown-out suppressed");
    bod_cmp_i <= 1'b0;
    wr(rbc_pkg::IDX_CFG_BOD, 8'hFF);
    pin(rbc_pkg::PIN_CYC + 2, s);
    rd_chk(rbc_pkg::IDX_STATUS, 32'h00000000, "flag clear before");
    @(posedge clk_i);
    bod_cmp_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk({31'h0, cpu_reset_o}, 32'h1, "brown-out resets");
    bod_cmp_i <= 1'b0;
    wait_run();
    pin(rbc_pkg::PIN_CYC + 2, s);
    rd_chk(rbc_pkg::IDX_STATUS, 32'h00000004, "flag set and kept");
    wr(rbc_pkg::IDX_STATUS, 8'h00);
    rd_chk(rbc_pkg::IDX_STATUS, 32'h00000000, "flag cleared");
    $display("test brown-out done");
  endtask

  // ****************************************
  // verdict, the one place the run ends
  // ****************************************
  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    errors = 0;
    n_compared = 0;
    srst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 10'h000;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h00000000;
    rst_pin_i = 1'b0;
    bod_cmp_i = 1'b0;
    repeat (12) @(posedge clk_i);
    srst_i <= 1'b0;
    t_reset_values();
    t_pin();
    t_config();
    t_soft_reset();
    t_brownout();
    conclude();
  end
endmodule // tb
